// *** rtl/pocfg_pkg.sv ***
// constants and types for the protection configuration and retry block
package pocfg_pkg;
    // ==========================================================
    // register map
    localparam logic       REG_THRESHOLD  = 1'h0;
    localparam logic       REG_PROT_TYPE  = 1'h1;
    localparam logic [7:0] THR_RESET      = 8'h08;
    localparam logic [7:0] PROT_RESET     = 8'h42;
    localparam int         THR_USED_W     = 5;
    localparam int         PG_BIT         = 4;
    localparam int         OV_LSB         = 2;
    localparam int         UV_LSB         = 0;
    localparam int         TRK_EN_BIT     = 7;
    localparam int         PHV_EN_BIT     = 6;
    // ==========================================================
    // protection order in fault, latch and status vectors
    localparam int         N_PROT         = 6;
    localparam int         P_TRACK        = 5;
    localparam int         P_PHASE        = 0;
    // ==========================================================
    // threshold percentages
    localparam logic [7:0] PG_LO_PCT      = 8'h5A;
    localparam logic [7:0] PG_HI_PCT      = 8'h5F;
    localparam logic [7:0] OV_110_PCT     = 8'h6E;
    localparam logic [7:0] OV_120_PCT     = 8'h78;
    localparam logic [7:0] OV_130_PCT     = 8'h82;
    localparam logic [7:0] UV_75_PCT      = 8'h4B;
    localparam logic [7:0] UV_80_PCT      = 8'h50;
    localparam logic [7:0] UV_85_PCT      = 8'h55;
    // ==========================================================
    // timing
    localparam int         CLOCK_HZ       = 25000000;
    localparam int         RETRY_TIME_MS  = 130;
    localparam int         RETRY_CYCLES   = (CLOCK_HZ / 1000) * RETRY_TIME_MS;
    // ==========================================================
    // modes
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_RETRY,
        MODE_LATCHED
    } pocfg_mode_t;
endpackage : pocfg_pkg

// *** rtl/pocfg_protect.sv ***
// protection threshold registers and fault retry / lock-out sequencing
module pocfg_protect #(
    parameter int SETPOINT_W = 16,
    parameter int RETRY_CYC  = pocfg_pkg::RETRY_CYCLES
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // register port
    input  wire logic                  reg_sel,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    // setpoint and thresholds
    input  wire logic [SETPOINT_W-1:0] output_setpoint,
    output logic      [SETPOINT_W-1:0] overvoltage_threshold,
    output logic      [SETPOINT_W-1:0] undervoltage_threshold,
    output logic      [SETPOINT_W-1:0] power_good_low_threshold,
    // fault detectors and host controls
    input  wire logic [5:0]            fault_condition,
    input  wire logic [5:0]            status_clear,
    input  wire logic                  turn_on,
    // converter control and status
    output logic                       output_enable,
    output logic                       ramp_start,
    output logic [5:0]                 fault_status_register
);
    import pocfg_pkg::*;

    localparam int CNT_W = $clog2(RETRY_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RETRY_CYC - 1);

    typedef struct packed {
        logic [THR_USED_W-1:0] thr_cfg;
        logic [7:0]            prot_cfg;
        logic [7:0]            rdata;
        logic [SETPOINT_W-1:0] ov_thr;
        logic [SETPOINT_W-1:0] uv_thr;
        logic [SETPOINT_W-1:0] pg_thr;
        pocfg_mode_t           mode;
        logic [CNT_W-1:0]      timer;
        logic                  timer_done;
        logic [N_PROT-1:0]     tripped;
        logic                  rearm;
        logic                  ramp;
        logic                  out_en;
    } pocfg_state_t;

    pocfg_state_t s_ff;
    pocfg_state_t nxt_s;
    logic [N_PROT-1:0] en_mask;
    logic [N_PROT-1:0] active;

    // ==========================================================
    // scaling of setpoint by a percentage
    function automatic logic [SETPOINT_W-1:0] scale(
        input logic [SETPOINT_W-1:0] sp,
        input logic [7:0]            pct
    );
        logic [SETPOINT_W+7:0] prod;
        prod  = sp * pct;
        scale = SETPOINT_W'(prod / 100);
    endfunction : scale

    function automatic logic [7:0] ov_pct(input logic [1:0] code);
        case (code)
            2'h0:    ov_pct = OV_110_PCT;
            2'h1:    ov_pct = OV_120_PCT;
            default: ov_pct = OV_130_PCT;
        endcase
    endfunction : ov_pct

    function automatic logic [7:0] uv_pct(input logic [1:0] code);
        case (code)
            2'h1:    uv_pct = UV_80_PCT;
            2'h2:    uv_pct = UV_85_PCT;
            default: uv_pct = UV_75_PCT;
        endcase
    endfunction : uv_pct

    // ==========================================================
    // enabled fault conditions
    always_comb begin
        en_mask          = '1;
        en_mask[P_TRACK] = s_ff.prot_cfg[TRK_EN_BIT];
        en_mask[P_PHASE] = s_ff.prot_cfg[PHV_EN_BIT];
        active           = fault_condition & en_mask;
    end

    // ==========================================================
    // next state
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.ramp = 1'b0;
        if (reg_wr) begin
            if (reg_sel == REG_THRESHOLD)
                nxt_s.thr_cfg = reg_wdata[THR_USED_W-1:0];
            else
                nxt_s.prot_cfg = reg_wdata;
        end
        if (reg_rd) begin
            if (reg_sel == REG_THRESHOLD)
                nxt_s.rdata = {3'h0, s_ff.thr_cfg};
            else
                nxt_s.rdata = s_ff.prot_cfg;
        end
        // thresholds track the live setpoint
        nxt_s.pg_thr = scale(output_setpoint, s_ff.thr_cfg[PG_BIT] ?
                             PG_HI_PCT : PG_LO_PCT);
        nxt_s.ov_thr = scale(output_setpoint,
                             ov_pct(s_ff.thr_cfg[OV_LSB+:2]));
        nxt_s.uv_thr = scale(output_setpoint,
                             uv_pct(s_ff.thr_cfg[UV_LSB+:2]));
        // interval timer
        if (!s_ff.timer_done) begin
            if (s_ff.timer == CNT_LAST)
                nxt_s.timer_done = 1'b1;
            else
                nxt_s.timer = s_ff.timer + 1'b1;
        end
        case (s_ff.mode)
            MODE_RUN: begin
                if (|active) begin
                    nxt_s.tripped    = active;
                    nxt_s.timer      = '0;
                    nxt_s.timer_done = 1'b0;
                    nxt_s.rearm      = 1'b0;
                    if (|(active & s_ff.prot_cfg[N_PROT-1:0]))
                        nxt_s.mode = MODE_LATCHED;
                    else
                        nxt_s.mode = MODE_RETRY;
                end
            end
            MODE_RETRY: begin
                nxt_s.tripped = s_ff.tripped | active;
                if (s_ff.timer_done) begin
                    if (active == '0) begin
                        nxt_s.mode    = MODE_RUN;
                        nxt_s.ramp    = 1'b1;
                        nxt_s.tripped = '0;
                    end else begin
                        nxt_s.timer      = '0;
                        nxt_s.timer_done = 1'b0;
                    end
                end
            end
            MODE_LATCHED: begin
                nxt_s.tripped = (s_ff.tripped & ~status_clear)
                              | active;
                if (!turn_on)
                    nxt_s.rearm = 1'b1;
                if (s_ff.timer_done && active == '0 &&
                    ((s_ff.tripped & ~status_clear) == '0 ||
                     (s_ff.rearm && turn_on))) begin
                    nxt_s.mode    = MODE_RUN;
                    nxt_s.ramp    = 1'b1;
                    nxt_s.tripped = '0;
                end
            end
            default: nxt_s.mode = MODE_RUN;
        endcase
        nxt_s.out_en = (nxt_s.mode == MODE_RUN) && turn_on;
        if (sys_rst) begin
            nxt_s            = '0;
            nxt_s.thr_cfg    = THR_RESET[THR_USED_W-1:0];
            nxt_s.prot_cfg   = PROT_RESET;
            nxt_s.mode       = MODE_RUN;
            nxt_s.timer_done = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        s_ff <= nxt_s;
    end

    // ==========================================================
    // outputs
    assign reg_rdata                = s_ff.rdata;
    assign overvoltage_threshold    = s_ff.ov_thr;
    assign undervoltage_threshold   = s_ff.uv_thr;
    assign power_good_low_threshold = s_ff.pg_thr;
    assign output_enable            = s_ff.out_en;
    assign ramp_start               = s_ff.ramp;
    assign fault_status_register    = ~s_ff.tripped;

    // ==========================================================
    // checks
    a_unused_zero: assert property (@(posedge clock) disable iff (sys_rst)
        reg_rd && reg_sel == REG_THRESHOLD |=> reg_rdata[7:5] == 3'h0)
        else $error("unused threshold bits not zero");
    a_pg_level: assert property (@(posedge clock) disable iff (sys_rst)
        s_ff.thr_cfg[PG_BIT] |=> power_good_low_threshold ==
        scale($past(output_setpoint), PG_HI_PCT))
        else $error("power-good low not 95 percent");
    a_ov_level: assert property (@(posedge clock) disable iff (sys_rst)
        s_ff.thr_cfg[OV_LSB+:2] == 2'h0 |=> overvoltage_threshold ==
        scale($past(output_setpoint), OV_110_PCT))
        else $error("overvoltage not 110 percent");
    a_uv_level: assert property (@(posedge clock) disable iff (sys_rst)
        s_ff.thr_cfg[UV_LSB+:2] == 2'h1 |=> undervoltage_threshold ==
        scale($past(output_setpoint), UV_80_PCT))
        else $error("undervoltage not 80 percent");
    a_track_off: assert property (@(posedge clock) disable iff (sys_rst)
        s_ff.mode == MODE_RUN && !s_ff.prot_cfg[TRK_EN_BIT] &&
        fault_condition == 6'h20 |=> s_ff.mode == MODE_RUN)
        else $error("disabled tracking fault tripped");
    a_phase_off: assert property (@(posedge clock) disable iff (sys_rst)
        s_ff.mode == MODE_RUN && !s_ff.prot_cfg[PHV_EN_BIT] &&
        fault_condition == 6'h01 |=> s_ff.mode == MODE_RUN)
        else $error("disabled phase check tripped");
    a_latch_off: assert property (@(posedge clock) disable iff (sys_rst)
        s_ff.mode == MODE_RUN && |(active & s_ff.prot_cfg[5:0])
        |=> s_ff.mode == MODE_LATCHED && !output_enable)
        else $error("latching trip did not lock off");
    a_retry_go: assert property (@(posedge clock) disable iff (sys_rst)
        s_ff.mode == MODE_RETRY && s_ff.timer_done && active == '0
        |=> ramp_start && s_ff.mode == MODE_RUN)
        else $error("retry did not restart with ramp");
    a_lock_hold: assert property (@(posedge clock) disable iff (sys_rst)
        s_ff.mode == MODE_LATCHED && !s_ff.timer_done
        |=> s_ff.mode == MODE_LATCHED && !ramp_start)
        else $error("latched restart before interval");
    a_timer_start: assert property (@(posedge clock) disable iff (sys_rst)
        s_ff.mode == MODE_RUN && |active
        |=> s_ff.timer == '0 && !s_ff.timer_done)
        else $error("interval timer not restarted at trip");
    a_status_low: assert property (@(posedge clock) disable iff (sys_rst)
        |active |=> (fault_status_register & $past(active)) == '0)
        else $error("tripped status bit not low");
endmodule : pocfg_protect

// *** bench/pocfg_host.sv ***
// host model driving the register select and strobe port
module pocfg_host (
    // clock
    input  wire logic       clock,
    // register port
    output logic            reg_sel,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // idle port
    initial begin
        reg_sel   = 1'h0;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
        reg_wdata = 8'h00;
    end
    // ==========================================================
    // one write, one strobe cycle
    task automatic wr(input logic s, input logic [7:0] d);
        @(posedge clock);
        reg_sel   <= s;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clock);
        reg_wr    <= 1'h0;
    endtask : wr
    // ==========================================================
    // one read, data taken a cycle after the strobe edge
    task automatic rd(input logic s, output logic [7:0] d);
        @(posedge clock);
        reg_sel <= s;
        reg_rd  <= 1'h1;
        @(posedge clock);
        reg_rd  <= 1'h0;
        @(posedge clock);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : pocfg_host

// *** bench/tb.sv ***
// self-checking bench for the protection configuration and retry block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pocfg_pkg::*;
    localparam int RC = 20;
    typedef struct packed {
        logic [7:0]  wd;
        logic [7:0]  rb;
        logic [15:0] ov;
        logic [15:0] uv;
        logic [15:0] pg;
    } pocfg_row_t;
    localparam pocfg_row_t ROWS [5] = '{
        '{8'h00, 8'h00, 16'h044C, 16'h02EE, 16'h0384},
        '{8'h05, 8'h05, 16'h04B0, 16'h0320, 16'h0384},
        '{8'h0A, 8'h0A, 16'h0514, 16'h0352, 16'h0384},
        '{8'h1F, 8'h1F, 16'h0514, 16'h02EE, 16'h03B6},
        '{8'hE6, 8'h06, 16'h04B0, 16'h0352, 16'h0384}};
    logic        clock, sys_rst, reg_sel, reg_wr, reg_rd, turn_on;
    logic        output_enable, ramp_start;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic [15:0] output_setpoint, ov_thr, uv_thr, pg_thr;
    logic [5:0]  fault_condition, status_clear, fault_status_register;
    int          fails, samples_checked, cycles, n;
    initial begin
        clock = 1'h0; sys_rst = 1'h1; turn_on = 1'h1;
        output_setpoint = 16'h03E8; fault_condition = 6'h00;
        status_clear = 6'h00; fails = 0; samples_checked = 0; cycles = 0;
    end
    always #20 clock = ~clock;
    // ==========================================================
    // design and host
    pocfg_protect #(.SETPOINT_W(16), .RETRY_CYC(RC)) uut (
        .clock(clock), .sys_rst(sys_rst), .reg_sel(reg_sel),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .output_setpoint(output_setpoint),
        .overvoltage_threshold(ov_thr), .undervoltage_threshold(uv_thr),
        .power_good_low_threshold(pg_thr),
        .fault_condition(fault_condition), .status_clear(status_clear),
        .turn_on(turn_on), .output_enable(output_enable),
        .ramp_start(ramp_start),
        .fault_status_register(fault_status_register));
    pocfg_host host (.clock(clock), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // ==========================================================
    // helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : chk
    task automatic summarize();
        if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic trip(input logic [5:0] f);
        @(posedge clock);
        fault_condition <= f;
        @(posedge clock);
        fault_condition <= 6'h00;
        #1;
    endtask : trip
    task automatic wait_ramp(output int k);
        k = 0;
        do begin
            @(posedge clock);
            #1;
            k++;
        end while (ramp_start !== 1'h1 && k < 400);
    endtask : wait_ramp
    task automatic idle(input int k, output int p);
        p = 0;
        repeat (k) begin
            @(posedge clock);
            #1;
            if (ramp_start === 1'h1)
                p++;
        end
    endtask : idle
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'h0;
        host.rd(REG_THRESHOLD, d);
        chk(16'(d), 16'(THR_RESET));
        chk(ov_thr, 16'h0514);
        chk(uv_thr, 16'h02EE);
        chk(pg_thr, 16'h0384);
        host.rd(REG_PROT_TYPE, d);
        chk(16'(d), 16'(PROT_RESET));
        chk(16'(fault_status_register), 16'h003F);
        foreach (ROWS[i]) begin
            host.wr(REG_THRESHOLD, ROWS[i].wd);
            host.rd(REG_THRESHOLD, d);
            chk(16'(d), 16'(ROWS[i].rb));
            chk(ov_thr, ROWS[i].ov);
            chk(uv_thr, ROWS[i].uv);
            chk(pg_thr, ROWS[i].pg);
        end
        @(posedge clock);
        output_setpoint <= 16'h07D0;
        repeat (3) @(posedge clock);
        #1;
        chk(ov_thr, 16'h0960);
        chk(uv_thr, 16'h06A4);
        chk(pg_thr, 16'h0708);
        host.wr(REG_PROT_TYPE, 8'h00);
        trip(6'h21);
        chk(16'(output_enable), 16'h0001);
        trip(6'h20);
        chk(16'(output_enable), 16'h0001);
        trip(6'h01);
        chk(16'(output_enable), 16'h0001);
        host.wr(REG_PROT_TYPE, 8'hC0);
        host.rd(REG_PROT_TYPE, d);
        chk(16'(d), 16'h00C0);
        trip(6'h21);
        chk(16'(output_enable), 16'h0000);
        chk(16'(fault_status_register), 16'h001E);
        wait_ramp(n);
        chk(16'(n >= RC - 1 && n <= RC + 3), 16'h0001);
        #40;
        chk(16'(output_enable), 16'h0001);
        chk(16'(fault_status_register), 16'h003F);
        @(posedge clock);
        fault_condition <= 6'h04;
        idle(2 * RC + 5, n);
        chk(16'(n), 16'h0000);
        @(posedge clock);
        fault_condition <= 6'h00;
        wait_ramp(n);
        chk(16'(n <= RC + 3), 16'h0001);
        for (int i = 0; i < 6; i++) begin
            host.wr(REG_PROT_TYPE, 8'hC0 | (8'h01 << i));
            trip(6'h01 << i);
            idle(RC + 10, n);
            chk(16'(n), 16'h0000);
            chk(16'(output_enable), 16'h0000);
            chk(16'(fault_status_register), {10'h0, ~(6'h01 << i)});
            @(posedge clock);
            status_clear <= 6'h01 << i;
            @(posedge clock);
            status_clear <= 6'h00;
            #1;
            chk(16'(ramp_start), 16'h0001);
            chk(16'(output_enable), 16'h0001);
        end
        trip(6'h20);
        @(posedge clock);
        turn_on <= 1'h0;
        repeat (2) @(posedge clock);
        turn_on <= 1'h1;
        wait_ramp(n);
        chk(16'(n >= RC - 4 && n <= RC + 4), 16'h0001);
        @(posedge clock);
        sys_rst <= 1'h1;
        @(posedge clock);
        sys_rst <= 1'h0;
        host.rd(REG_PROT_TYPE, d);
        chk(16'(d), 16'(PROT_RESET));
        summarize();
    end
endmodule : tb
